// >>> verilog/tapcfg_pkg.sv
// How it works
// - set A holds all 96 bits; set B keeps only its capacitor field
// - programming interrupts operation and starts on entry to Run-Test/Idle
// - bypass code all ones puts the one-bit bypass stage on the scan path
// - sample/preload behaves exactly like bypass
// - external test code all zeros behaves exactly like bypass
// - identification puts a 32-bit maker, part and version word on the path
// - identification is selected after power-up or Test-Logic-Reset
// - verify A or B copies the stored set into the config shift stage
// - verify A returns valid data only while the set-select bit is 0
// - calibration holds every output at the mid reference until done
// - calibration starts on Run-Test/Idle entry and finishes unattended
// - bulk erase interrupts, disconnects inputs, parks outputs at reference
// - programming only sets bits; bulk erase clears the whole set at once
// - path select and test codes act in Update-IR; the rest on idle entry
// - five-bit instruction codes as listed in this package
// - the config shift stage is 96 bits long
// - Capture-IR always loads the identification code
// - TDI and TMS sampled on rising test clock, TDO changes on falling
`default_nettype none
package tapcfg_pkg;
  localparam int IR_W = 5;
  localparam int ID_W = 32;
  localparam int CFG_W = 96;
  localparam int CAPB_W = 64;
  localparam int SEL_BIT = 95;
  localparam logic [IR_W-1:0] IR_EXTEST = 5'h00;
  localparam logic [IR_W-1:0] IR_SELECT_CONFIG_PATH = 5'h01;
  localparam logic [IR_W-1:0] IR_ERASE_SET_A = 5'h02;
  localparam logic [IR_W-1:0] IR_ERASE_SET_B = 5'h03;
  localparam logic [IR_W-1:0] IR_VERIFY_SET_A = 5'h04;
  localparam logic [IR_W-1:0] IR_VERIFY_SET_B = 5'h05;
  localparam logic [IR_W-1:0] IR_PROGRAM_SET_A = 5'h06;
  localparam logic [IR_W-1:0] IR_PROGRAM_SET_B = 5'h07;
  localparam logic [IR_W-1:0] IR_START_AUTOCAL = 5'h0c;
  localparam logic [IR_W-1:0] IR_IDCODE = 5'h0d;
  localparam logic [IR_W-1:0] IR_SAMPLE = 5'h1e;
  localparam logic [IR_W-1:0] IR_BYPASS = 5'h1f;
  // identity fields, values arbitrary
  localparam logic [3:0] ID_VERSION = 4'h1;
  localparam logic [15:0] ID_PART = 16'h0a5c;
  localparam logic [10:0] ID_MAKER = 11'h123;
  localparam logic [ID_W-1:0] ID_VALUE = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};
  // timing
  localparam int CLK_MHZ = 40;
  localparam int PROG_TIME_US = 100000;
  localparam int CAL_TIME_US = 20000;
  localparam int PROG_CYCLES_DEF = PROG_TIME_US * CLK_MHZ;
  localparam int CAL_CYCLES_DEF = CAL_TIME_US * CLK_MHZ;
  typedef enum logic [3:0] {
    ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PA_DR, ST_EX2_DR,
    ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PA_IR, ST_EX2_IR, ST_UPD_IR
  } tap_state_t;
  typedef enum logic [1:0] {OP_NONE, OP_ERASE, OP_PROG, OP_READ} mem_op_t;
  typedef enum logic [1:0] {PATH_BYP, PATH_ID, PATH_CFG} dr_path_t;
endpackage
`default_nettype wire

// >>> verilog/nv_if.sv
`default_nettype none
interface nv_if;
  import tapcfg_pkg::*;
  mem_op_t op;
  logic set_b;
  logic [CFG_W-1:0] wdata;
  logic [CFG_W-1:0] rdata;
  logic [CFG_W-1:0] a_bits;
  logic [CAPB_W-1:0] b_bits;
  modport ctrl (output op, output set_b, output wdata, input rdata, input a_bits, input b_bits);
  modport mem (input op, input set_b, input wdata, output rdata, output a_bits, output b_bits);
endinterface
`default_nettype wire

// >>> verilog/nv_cfg_mem.sv
`default_nettype none
module nv_cfg_mem (
  input wire logic clk_i,
  input wire logic rst_n_i,
  nv_if.mem nv
);
  import tapcfg_pkg::*;
  logic [CFG_W-1:0] store_a_ff;
  logic [CAPB_W-1:0] store_b_ff;
  logic [CFG_W-1:0] rdata_ff;

  // set storage: programming ors in ones, erase clears all
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      store_a_ff <= '0;
      store_b_ff <= '0;
    end else if (nv.op == OP_ERASE) begin
      if (nv.set_b) store_b_ff <= '0;
      else store_a_ff <= '0;
    end else if (nv.op == OP_PROG) begin
      if (nv.set_b) store_b_ff <= store_b_ff | nv.wdata[CAPB_W-1:0];
      else store_a_ff <= store_a_ff | nv.wdata;
    end
  end

  // registered read-out for verify
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rdata_ff <= '0;
    end else if (nv.op == OP_READ) begin
      if (nv.set_b) rdata_ff <= {{(CFG_W-CAPB_W){1'b0}}, store_b_ff};
      else if (store_a_ff[SEL_BIT]) rdata_ff <= '0;
      else rdata_ff <= store_a_ff;
    end
  end

  assign nv.rdata = rdata_ff;
  assign nv.a_bits = store_a_ff;
  assign nv.b_bits = store_b_ff;

  property p_erase_clears;
    @(posedge clk_i) disable iff (!rst_n_i)
    (nv.op == OP_ERASE && !nv.set_b) |=> (store_a_ff == '0);
  endproperty
  a_erase_clears: assert property (p_erase_clears) else $error("erase left bits set");

  property p_prog_sets_only;
    @(posedge clk_i) disable iff (!rst_n_i)
    (nv.op == OP_PROG) |=> ((store_a_ff & $past(store_a_ff)) == $past(store_a_ff));
  endproperty
  a_prog_sets_only: assert property (p_prog_sets_only) else $error("program cleared a bit");

  property p_verify_a_blocked;
    @(posedge clk_i) disable iff (!rst_n_i)
    (nv.op == OP_READ && !nv.set_b && store_a_ff[SEL_BIT]) |=> (rdata_ff == '0);
  endproperty
  a_verify_a_blocked: assert property (p_verify_a_blocked) else $error("verify A not blocked");
endmodule // nv_cfg_mem
`default_nettype wire

// >>> verilog/tap_cfg_port.sv
`default_nettype none
module tap_cfg_port #(
  parameter int PROG_CYCLES = tapcfg_pkg::PROG_CYCLES_DEF,
  parameter int CAL_CYCLES = tapcfg_pkg::CAL_CYCLES_DEF
) (
  input wire logic REF_CLK_I,
  input wire logic NRST_I,
  input wire logic TCK_I,
  input wire logic TMS_I,
  input wire logic TDI_I,
  output logic TDO_O,
  output logic TDO_OE_O,
  output logic [tapcfg_pkg::CFG_W-1:0] CONFIG_A_O,
  output logic [tapcfg_pkg::CAPB_W-1:0] CONFIG_B_O,
  output logic ACTIVE_SET_B_O,
  output logic OP_INTERRUPT_O,
  output logic INPUTS_OFF_O,
  output logic MID_REF_O,
  output logic CAL_BUSY_O
);
  import tapcfg_pkg::*;

  logic tck_s1_ff, tck_s2_ff, tck_s3_ff;
  logic tms_s1_ff, tms_s2_ff, tdi_s1_ff, tdi_s2_ff;
  logic tck_rise, tck_fall;
  tap_state_t tap_ff, nxt_tap;
  logic [IR_W-1:0] ir_sh_ff, ir_ff;
  logic [ID_W-1:0] id_sh_ff;
  logic [CFG_W-1:0] cfg_sh_ff;
  logic byp_ff;
  dr_path_t path;
  logic tdo_ff, tdo_oe_ff;
  logic idle_entry, leave_idle;
  mem_op_t pend_ff;
  logic pend_b_ff;
  logic [31:0] dwell_ff;
  logic [31:0] cal_ff;
  mem_op_t req_ff;
  logic req_b_ff;
  logic load_ff;
  nv_if nv ();

  nv_cfg_mem u_mem (.clk_i(REF_CLK_I), .rst_n_i(NRST_I), .nv(nv.mem));

  // pin synchronisers; third tck stage only for edge finding
  always_ff @(posedge REF_CLK_I) begin
    if (!NRST_I) begin
      {tck_s1_ff, tck_s2_ff, tck_s3_ff} <= 3'h0;
      {tms_s1_ff, tms_s2_ff, tdi_s1_ff, tdi_s2_ff} <= 4'hf;
    end else begin
      tck_s1_ff <= TCK_I;
      tck_s2_ff <= tck_s1_ff;
      tck_s3_ff <= tck_s2_ff;
      tms_s1_ff <= TMS_I;
      tms_s2_ff <= tms_s1_ff;
      tdi_s1_ff <= TDI_I;
      tdi_s2_ff <= tdi_s1_ff;
    end
  end
  assign tck_rise = tck_s2_ff & ~tck_s3_ff;
  assign tck_fall = ~tck_s2_ff & tck_s3_ff;

  // standard tap next state
  always_comb begin
    case (tap_ff)
      ST_RESET: nxt_tap = tms_s2_ff ? ST_RESET : ST_IDLE;
      ST_IDLE: nxt_tap = tms_s2_ff ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: nxt_tap = tms_s2_ff ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: nxt_tap = tms_s2_ff ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR: nxt_tap = tms_s2_ff ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: nxt_tap = tms_s2_ff ? ST_UPD_DR : ST_PA_DR;
      ST_PA_DR: nxt_tap = tms_s2_ff ? ST_EX2_DR : ST_PA_DR;
      ST_EX2_DR: nxt_tap = tms_s2_ff ? ST_UPD_DR : ST_SH_DR;
      ST_UPD_DR: nxt_tap = tms_s2_ff ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: nxt_tap = tms_s2_ff ? ST_RESET : ST_CAP_IR;
      ST_CAP_IR: nxt_tap = tms_s2_ff ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR: nxt_tap = tms_s2_ff ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: nxt_tap = tms_s2_ff ? ST_UPD_IR : ST_PA_IR;
      ST_PA_IR: nxt_tap = tms_s2_ff ? ST_EX2_IR : ST_PA_IR;
      ST_EX2_IR: nxt_tap = tms_s2_ff ? ST_UPD_IR : ST_SH_IR;
      ST_UPD_IR: nxt_tap = tms_s2_ff ? ST_SEL_DR : ST_IDLE;
      default: nxt_tap = ST_RESET;
    endcase
  end

  // tap state advances on tck rising edge
  always_ff @(posedge REF_CLK_I) begin
    if (!NRST_I) tap_ff <= ST_RESET;
    else if (tck_rise) tap_ff <= nxt_tap;
  end

  assign idle_entry = tck_rise && (tap_ff != ST_IDLE) && (nxt_tap == ST_IDLE);
  assign leave_idle = tck_rise && (tap_ff == ST_IDLE) && (nxt_tap != ST_IDLE);

  // instruction stages; new code lands entering Update-IR so idle entry already sees it
  always_ff @(posedge REF_CLK_I) begin
    if (!NRST_I) begin
      ir_sh_ff <= IR_IDCODE;
      ir_ff <= IR_IDCODE;
    end else if (tap_ff == ST_RESET) begin
      ir_ff <= IR_IDCODE;
    end else if (tck_rise) begin
      if (tap_ff == ST_CAP_IR) ir_sh_ff <= IR_IDCODE;
      else if (tap_ff == ST_SH_IR) ir_sh_ff <= {tdi_s2_ff, ir_sh_ff[IR_W-1:1]};
      else if (nxt_tap == ST_UPD_IR) ir_ff <= ir_sh_ff;
    end
  end

  // data path decode; unknown and boundary codes go to bypass
  always_comb begin
    case (ir_ff)
      IR_IDCODE: path = PATH_ID;
      IR_SELECT_CONFIG_PATH: path = PATH_CFG;
      IR_BYPASS, IR_SAMPLE, IR_EXTEST: path = PATH_BYP;
      default: path = PATH_BYP;
    endcase
  end

  // data shift stages; config stage keeps its contents on capture
  always_ff @(posedge REF_CLK_I) begin
    if (!NRST_I) begin
      id_sh_ff <= ID_VALUE;
      byp_ff <= 1'b0;
      cfg_sh_ff <= '0;
    end else if (load_ff) begin
      cfg_sh_ff <= nv.rdata;
    end else if (tck_rise && tap_ff == ST_CAP_DR) begin
      id_sh_ff <= ID_VALUE;
      byp_ff <= 1'b0;
    end else if (tck_rise && tap_ff == ST_SH_DR) begin
      case (path)
        PATH_ID: id_sh_ff <= {tdi_s2_ff, id_sh_ff[ID_W-1:1]};
        PATH_CFG: cfg_sh_ff <= {tdi_s2_ff, cfg_sh_ff[CFG_W-1:1]};
        default: byp_ff <= tdi_s2_ff;
      endcase
    end
  end

  // tdo updated on falling tck
  always_ff @(posedge REF_CLK_I) begin
    if (!NRST_I) begin
      tdo_ff <= 1'b0;
      tdo_oe_ff <= 1'b0;
    end else if (tck_fall) begin
      tdo_oe_ff <= (tap_ff == ST_SH_IR) || (tap_ff == ST_SH_DR);
      if (tap_ff == ST_SH_IR) tdo_ff <= ir_sh_ff[0];
      else if (path == PATH_ID) tdo_ff <= id_sh_ff[0];
      else if (path == PATH_CFG) tdo_ff <= cfg_sh_ff[0];
      else tdo_ff <= byp_ff;
    end
  end

  // program/erase: armed on idle entry, committed after full dwell
  always_ff @(posedge REF_CLK_I) begin
    if (!NRST_I) begin
      pend_ff <= OP_NONE;
      pend_b_ff <= 1'b0;
      dwell_ff <= '0;
    end else if (idle_entry) begin
      dwell_ff <= '0;
      pend_b_ff <= ir_ff[0];
      if (ir_ff == IR_PROGRAM_SET_A || ir_ff == IR_PROGRAM_SET_B) pend_ff <= OP_PROG;
      else if (ir_ff == IR_ERASE_SET_A || ir_ff == IR_ERASE_SET_B) pend_ff <= OP_ERASE;
      else pend_ff <= OP_NONE;
    end else if (leave_idle) begin
      pend_ff <= OP_NONE;
    end else if (pend_ff != OP_NONE) begin
      if (dwell_ff == 32'(PROG_CYCLES - 1)) pend_ff <= OP_NONE;
      else dwell_ff <= dwell_ff + 32'h1;
    end
  end

  // one-cycle memory requests and verify load
  always_ff @(posedge REF_CLK_I) begin
    if (!NRST_I) begin
      req_ff <= OP_NONE;
      req_b_ff <= 1'b0;
      load_ff <= 1'b0;
    end else begin
      load_ff <= (req_ff == OP_READ);
      if (idle_entry && (ir_ff == IR_VERIFY_SET_A || ir_ff == IR_VERIFY_SET_B)) begin
        req_ff <= OP_READ;
        req_b_ff <= ir_ff[0];
      end else if (pend_ff != OP_NONE && !leave_idle && dwell_ff == 32'(PROG_CYCLES - 1)) begin
        req_ff <= pend_ff;
        req_b_ff <= pend_b_ff;
      end else begin
        req_ff <= OP_NONE;
      end
    end
  end

  // auto-calibration runs free of the tap once started
  always_ff @(posedge REF_CLK_I) begin
    if (!NRST_I) cal_ff <= '0;
    else if (idle_entry && ir_ff == IR_START_AUTOCAL) cal_ff <= 32'(CAL_CYCLES);
    else if (cal_ff != '0) cal_ff <= cal_ff - 32'h1;
  end

  assign nv.op = req_ff;
  assign nv.set_b = req_b_ff;
  assign nv.wdata = cfg_sh_ff;
  assign TDO_O = tdo_ff;
  assign TDO_OE_O = tdo_oe_ff;
  assign CONFIG_A_O = nv.a_bits;
  assign CONFIG_B_O = nv.b_bits;
  assign ACTIVE_SET_B_O = nv.a_bits[SEL_BIT];
  assign OP_INTERRUPT_O = (pend_ff != OP_NONE);
  assign INPUTS_OFF_O = (pend_ff == OP_ERASE);
  assign CAL_BUSY_O = (cal_ff != '0);
  assign MID_REF_O = CAL_BUSY_O || (pend_ff == OP_ERASE);

  property p_capture_id;
    @(posedge REF_CLK_I) disable iff (!NRST_I)
    (tck_rise && tap_ff == ST_CAP_IR) |=> (ir_sh_ff == IR_IDCODE);
  endproperty
  a_capture_id: assert property (p_capture_id) else $error("capture-IR not id");

  property p_reset_id;
    @(posedge REF_CLK_I) disable iff (!NRST_I)
    (tap_ff == ST_RESET) |=> (ir_ff == IR_IDCODE) && (path == PATH_ID);
  endproperty
  a_reset_id: assert property (p_reset_id) else $error("id not selected in reset");

  property p_nonid_bypass;
    @(posedge REF_CLK_I) disable iff (!NRST_I)
    (ir_ff != IR_IDCODE && ir_ff != IR_SELECT_CONFIG_PATH) |-> (path == PATH_BYP);
  endproperty
  a_nonid_bypass: assert property (p_nonid_bypass) else $error("bypass not chosen");

  property p_tdo_on_fall;
    @(posedge REF_CLK_I) disable iff (!NRST_I)
    !tck_fall |=> $stable(tdo_ff) && $stable(tdo_oe_ff);
  endproperty
  a_tdo_on_fall: assert property (p_tdo_on_fall) else $error("tdo moved off falling edge");

  property p_prog_start;
    @(posedge REF_CLK_I) disable iff (!NRST_I)
    (idle_entry && ir_ff == IR_PROGRAM_SET_A) |=> OP_INTERRUPT_O && !INPUTS_OFF_O;
  endproperty
  a_prog_start: assert property (p_prog_start) else $error("program did not interrupt");

  property p_erase_park;
    @(posedge REF_CLK_I) disable iff (!NRST_I)
    (idle_entry && ir_ff == IR_ERASE_SET_B) |=> INPUTS_OFF_O && MID_REF_O && OP_INTERRUPT_O;
  endproperty
  a_erase_park: assert property (p_erase_park) else $error("erase outputs wrong");

  property p_cal_start;
    @(posedge REF_CLK_I) disable iff (!NRST_I)
    (idle_entry && ir_ff == IR_START_AUTOCAL) |=> MID_REF_O ##1 MID_REF_O;
  endproperty
  a_cal_start: assert property (p_cal_start) else $error("calibration not started");

  property p_verify_load;
    @(posedge REF_CLK_I) disable iff (!NRST_I)
    (idle_entry && ir_ff == IR_VERIFY_SET_B) |=> (nv.op == OP_READ) ##2 (cfg_sh_ff == nv.rdata);
  endproperty
  a_verify_load: assert property (p_verify_load) else $error("verify data not loaded");

  c_program: cover property (@(posedge REF_CLK_I) disable iff (!NRST_I) nv.op == OP_PROG);
  c_erase: cover property (@(posedge REF_CLK_I) disable iff (!NRST_I) nv.op == OP_ERASE);
  c_verify: cover property (@(posedge REF_CLK_I) disable iff (!NRST_I) load_ff);
  c_cal_end: cover property (@(posedge REF_CLK_I) disable iff (!NRST_I) $fell(CAL_BUSY_O));
endmodule // tap_cfg_port
`default_nettype wire

// >>> testbench/jtag_host.sv
`default_nettype none
// programmer model: drives the link, test clock parked low between frames
module jtag_host (
  input wire logic clk_i,
  input wire logic tdo_i,
  output logic tck_o,
  output logic tms_o,
  output logic tdi_o
);
  timeunit 1ns;
  timeprecision 100ps;
  import tapcfg_pkg::*;
  // idle levels at time zero
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b0;
  end
  // one link period of eight system clocks; tdo taken just before the fall
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    @(posedge clk_i);
    #2;
    tms_o = tms;
    tdi_o = tdi;
    repeat (3) @(posedge clk_i);
    #2 tck_o = 1'b1;
    repeat (4) @(posedge clk_i);
    #2 tdo = tdo_i;
    tck_o = 1'b0;
  endtask
  // five high steps reach test reset, one low step parks in idle
  task automatic reset_tap();
    logic t;
    repeat (5) step(1'b1, 1'b0, t);
    step(1'b0, 1'b0, t);
  endtask
  // instruction or data scan from idle back to idle, lsb first
  task automatic scan(input logic ir, input int n, input logic [CFG_W-1:0] din,
                      output logic [CFG_W-1:0] dout);
    logic t;
    dout = '0;
    step(1'b1, 1'b0, t);
    if (ir) step(1'b1, 1'b0, t);
    step(1'b0, 1'b0, t);
    step(1'b0, 1'b0, t);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], t);
      dout[i] = t;
    end
    step(1'b1, 1'b0, t);
    step(1'b0, 1'b0, t);
  endtask
  task automatic load_ir(input logic [IR_W-1:0] code);
    logic [CFG_W-1:0] d;
    scan(1'b1, IR_W, CFG_W'(code), d);
  endtask
  // stay in idle with the clock still while an operation runs
  task automatic hold_idle(input int n);
    repeat (n) @(posedge clk_i);
    #2;
  endtask
  // verify, then path select, then shift the set out
  task automatic read_back(input logic [IR_W-1:0] code, output logic [CFG_W-1:0] dout);
    load_ir(code);
    load_ir(IR_SELECT_CONFIG_PATH);
    scan(1'b0, CFG_W, {CFG_W{1'b1}}, dout);
  endtask
endmodule // jtag_host
`default_nettype wire

// >>> testbench/jtag_config_program_port_bench.sv
`default_nettype none
module jtag_config_program_port_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import tapcfg_pkg::*;
  localparam int PROG_N = 40;
  localparam int CAL_N = 24;
  localparam int LIMIT = 40000;
  logic ref_clk = 1'b0;
  logic nrst;
  logic tck, tms, tdi, tdo, tdo_oe, set_b, op_int, in_off, mid_ref, cal_busy;
  logic [CFG_W-1:0] cfg_a, exp_a, v, d;
  logic [CAPB_W-1:0] cfg_b, exp_b;
  logic [31:0] lfsr_q = 32'h0000_0032;
  logic [IR_W-1:0] byp_codes [8];
  int err_count = 0;
  int total_checks = 0;
  int cyc = 0;
  // system clock
  always #12.5 ref_clk = ~ref_clk;
  tap_cfg_port #(.PROG_CYCLES(PROG_N), .CAL_CYCLES(CAL_N)) dut_u (
    .REF_CLK_I(ref_clk), .NRST_I(nrst), .TCK_I(tck), .TMS_I(tms), .TDI_I(tdi),
    .TDO_O(tdo), .TDO_OE_O(tdo_oe), .CONFIG_A_O(cfg_a), .CONFIG_B_O(cfg_b),
    .ACTIVE_SET_B_O(set_b), .OP_INTERRUPT_O(op_int), .INPUTS_OFF_O(in_off),
    .MID_REF_O(mid_ref), .CAL_BUSY_O(cal_busy)
  );
  // released tdo shows the inverse, so a missing output enable corrupts the read data
  jtag_host host_u (.clk_i(ref_clk), .tdo_i(tdo_oe ? tdo : ~tdo), .tck_o(tck), .tms_o(tms),
    .tdi_o(tdi));
  // next pseudo-random word
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // expected read-back of a set
  function automatic logic [CFG_W-1:0] rd_exp(input logic b, input logic [CFG_W-1:0] a,
                                              input logic [CAPB_W-1:0] bb);
    if (b) begin
      return CFG_W'(bb);
    end
    return a[SEL_BIT] ? '0 : a;
  endfunction
  // bypass stage: captured zero, then data one step late
  function automatic logic [7:0] byp_exp(input logic [7:0] din);
    return {din[6:0], 1'b0};
  endfunction
  task automatic rnd(output logic [CFG_W-1:0] r);
    for (int k = 0; k < 3; k++) begin
      lfsr_q = lfsr_next(lfsr_q);
      r[32*k +: 32] = lfsr_q;
    end
  endtask
  task automatic chk(input logic [CFG_W-1:0] got, input logic [CFG_W-1:0] want, input string m);
    total_checks++;
    if (got !== want) begin
      err_count++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  // shift data in, run one store operation with full dwell, compare both sets
  task automatic nv_op(input logic [IR_W-1:0] code, input logic [CFG_W-1:0] data);
    logic er;
    er = code inside {IR_ERASE_SET_A, IR_ERASE_SET_B};
    host_u.load_ir(IR_SELECT_CONFIG_PATH);
    host_u.scan(1'b0, CFG_W, data, d);
    host_u.load_ir(code);
    host_u.hold_idle(2);
    chk(CFG_W'({op_int, in_off, mid_ref}), CFG_W'({1'b1, er, er}), "op pending");
    host_u.hold_idle(PROG_N + 40);
    case (code)
      IR_ERASE_SET_A: exp_a = '0;
      IR_ERASE_SET_B: exp_b = '0;
      IR_PROGRAM_SET_A: exp_a = exp_a | data;
      default: exp_b = exp_b | data[CAPB_W-1:0];
    endcase
    chk(CFG_W'({op_int, in_off, mid_ref, set_b}), CFG_W'({3'b000, exp_a[SEL_BIT]}), "op end");
    chk(cfg_a, exp_a, "set a");
    chk(CFG_W'(cfg_b), CFG_W'(exp_b), "set b");
  endtask
  task automatic read_set(input logic b);
    host_u.read_back(b ? IR_VERIFY_SET_B : IR_VERIFY_SET_A, d);
    chk(d, rd_exp(b, exp_a, exp_b), "read back");
    chk(CFG_W'(op_int), '0, "verify left operation");
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // hang guard
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      err_count++;
      $display("BAD %0t timeout", $time);
      wrap_up();
    end
  end
  // main sequence
  initial begin
    nrst = 1'b0;
    exp_a = '0;
    exp_b = '0;
    byp_codes = '{IR_EXTEST, IR_SAMPLE, IR_BYPASS, 5'h08, 5'h0b, 5'h0e, 5'h1d, 5'h10};
    repeat (10) @(posedge ref_clk);
    #2 nrst = 1'b1;
    host_u.hold_idle(3);
    chk(CFG_W'({tdo_oe, op_int, in_off, mid_ref, cal_busy, set_b}), '0, "reset outputs");
    chk(cfg_a, '0, "reset set a");
    $display("test reset done");
    host_u.reset_tap();
    host_u.scan(1'b0, ID_W, '0, d);
    chk(CFG_W'(d[ID_W-1:0]), CFG_W'(ID_VALUE), "blind id");
    host_u.scan(1'b1, IR_W, CFG_W'(IR_IDCODE), d);
    chk(CFG_W'(d[IR_W-1:0]), CFG_W'(IR_IDCODE), "ir capture");
    host_u.scan(1'b0, ID_W, '0, d);
    chk(CFG_W'(d[ID_W-1:0]), CFG_W'(ID_VALUE), "loaded id");
    $display("test identify done");
    rnd(v);
    byp_codes[7] = 5'h0e + 5'(lfsr_q[3:0]);
    foreach (byp_codes[i]) begin
      rnd(v);
      host_u.load_ir(byp_codes[i]);
      host_u.scan(1'b0, 8, v, d);
      chk(CFG_W'(d[7:0]), CFG_W'(byp_exp(v[7:0])), "bypass path");
      chk(CFG_W'({op_int, mid_ref}), '0, "bypass quiet");
    end
    $display("test bypass done");
    rnd(v);
    v[SEL_BIT] = 1'b0;
    nv_op(IR_ERASE_SET_A, v);
    nv_op(IR_PROGRAM_SET_A, v);
    read_set(1'b0);
    rnd(v);
    v[SEL_BIT] = 1'b0;
    nv_op(IR_PROGRAM_SET_A, v);
    read_set(1'b0);
    rnd(v);
    nv_op(IR_ERASE_SET_B, v);
    nv_op(IR_PROGRAM_SET_B, v);
    read_set(1'b1);
    v[SEL_BIT] = 1'b1;
    nv_op(IR_PROGRAM_SET_A, v);
    read_set(1'b0);
    nv_op(IR_ERASE_SET_A, v);
    read_set(1'b0);
    $display("test store done");
    host_u.load_ir(IR_START_AUTOCAL);
    host_u.hold_idle(2);
    chk(CFG_W'({cal_busy, mid_ref, op_int, in_off}), CFG_W'(4'b1100), "cal running");
    host_u.hold_idle(CAL_N - 10);
    chk(CFG_W'({cal_busy, mid_ref}), CFG_W'(2'b11), "cal held");
    host_u.hold_idle(16);
    chk(CFG_W'({cal_busy, mid_ref}), '0, "cal finished");
    host_u.reset_tap();
    host_u.scan(1'b0, ID_W, '0, d);
    chk(CFG_W'(d[ID_W-1:0]), CFG_W'(ID_VALUE), "id after test reset");
    $display("test calibrate done");
    wrap_up();
  end
endmodule // jtag_config_program_port_bench
`default_nettype wire
